// >>> inc/nvcs_cfg.svh
// Purpose: Offsets, field positions, reset values and codes of the
//   nonvolatile configuration store and restore block.
// Assumes: Included by the block itself; the package does not include it.
// Notes: Definitions only.
`ifndef NVCS_CFG_SVH
`define NVCS_CFG_SVH

`define NVCS_OFF_CONTROL 8'h06
`define NVCS_OFF_GUARD 8'h13
`define NVCS_CMD_STORE 8'h15
`define NVCS_CMD_RESTORE 8'h16
`define NVCS_PAGE_WORD_LO 8'h1C
`define NVCS_PAGE_WORD_HI 8'h1D
`define NVCS_HI_SEL_SUM 8'h00
`define NVCS_HI_SEL_FAULT 8'h01
`define NVCS_GUARD_KEY 8'h63
`define NVCS_GUARD_OFF 8'h00
`define NVCS_CTRL_RESET 8'h00
`define NVCS_GUARD_RESET 8'h00
`define NVCS_CTRL_MASK 8'h07
`define NVCS_BIT_CRC_STOP 0
`define NVCS_BIT_FAULT_SAVE 1
`define NVCS_BIT_WORD_EN 2
`define NVCS_CML_CRC_BIT 4
`define NVCS_CRC_POLY 8'h07
`define NVCS_CRC_INIT 8'h00
`define NVCS_MEM_RESET 8'h00
`define NVCS_SUM_RESET 8'h00

`endif

// >>> inc/nvcs_pkg.sv
// Purpose: Types of the nonvolatile configuration store and restore block.
// Assumes: Nothing beyond the standard language.
// Notes: Sequencer states only.
package nvcs_pkg;
	typedef enum logic [1:0] {
		NVCS_IDLE,
		NVCS_STORE,
		NVCS_RESTORE
	} nvcs_state_t;
endpackage

// >>> hw/nvcs_store_restore.sv
// Purpose: Saves and restores the page 0 operating memory to and from a
//   nonvolatile array with a checksum; holds the control and write-guard
//   registers reached by decoded bus commands.
// Assumes: An upstream bus slave hands over one decoded command per pulse;
//   operating memory reads back combinationally on the same clock.
// Notes: The nonvolatile array is modelled in flip-flops.
`timescale 1ns/100ps
`default_nettype none
`include "nvcs_cfg.svh"

module nvcs_store_restore import nvcs_pkg::*; #(
	parameter int DEPTH = 16
) (
	input wire logic clock, // 250 MHz core clock
	input wire logic reset_n, // Asynchronous power-on reset
	input wire logic cmd_valid, // One-cycle decoded command strobe
	input wire logic [7:0] cmd_code, // Command code or word index
	input wire logic [7:0] cmd_page, // Page selected on the bus
	input wire logic cmd_write, // Write transaction when high
	input wire logic cmd_has_data, // A data byte follows the code
	input wire logic [7:0] cmd_wdata, // Write data byte
	output logic cmd_done, // Command completed pulse
	output logic cmd_err, // Command refused pulse
	output logic [7:0] cmd_rdata, // Read data, valid with cmd_done
	output logic [$clog2(DEPTH)-1:0] op_addr, // Operating memory index
	input wire logic [7:0] op_rdata, // Operating memory read data
	output logic op_we, // Operating memory write strobe
	output logic [7:0] op_wdata, // Operating memory write data
	input wire logic power_on, // Output power being delivered
	input wire logic fault_event, // Fault status report pulse
	input wire logic [7:0] fault_code, // Fault status to record
	input wire logic crc_fault_clear, // Clears checksum fault, shutdown
	output logic status_cml_crc, // Communication status bit 4
	output logic shutdown_req, // Stop output power, level
	output logic busy // Save or restore in progress
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	function automatic logic [7:0] nvcs_crc8(input logic [7:0] crc,
		input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ `NVCS_CRC_POLY) : (c << 1);
		end
		return c;
	endfunction

	logic rst_meta_reg, rst_n_sync;
	nvcs_state_t state_reg, state_next;
	logic [AW-1:0] idx_reg, idx_next;
	logic [7:0] crc_reg, crc_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] guard_reg, guard_next;
	logic [7:0] mem_reg [DEPTH];
	logic [7:0] mem_next [DEPTH];
	logic [7:0] sum_reg, sum_next;
	logic [7:0] frec_reg, frec_next;
	logic fault_reg, fault_next;
	logic stop_reg, stop_next;
	logic done_reg, done_next;
	logic err_reg, err_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] byte_in, crc_calc;
	logic last, unlocked, word_page, in_range;

	// Reset release through two flip-flops
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_sync <= rst_meta_reg;
		end
	end

	assign unlocked = (guard_reg == `NVCS_GUARD_KEY);
	assign word_page = (cmd_page == `NVCS_PAGE_WORD_LO) ||
		(cmd_page == `NVCS_PAGE_WORD_HI);
	assign in_range = (cmd_code < 8'(DEPTH));
	assign last = (idx_reg == LAST);
	assign byte_in = (state_reg == NVCS_STORE) ? op_rdata : mem_reg[idx_reg];
	assign crc_calc = nvcs_crc8(crc_reg, byte_in);

	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		crc_next = crc_reg;
		ctrl_next = ctrl_reg;
		guard_next = guard_reg;
		mem_next = mem_reg;
		sum_next = sum_reg;
		frec_next = frec_reg;
		fault_next = fault_reg;
		stop_next = stop_reg;
		done_next = 1'b0;
		err_next = 1'b0;
		rdata_next = rdata_reg;
		// Clear first so that a fault in the same cycle wins
		if (crc_fault_clear) begin
			fault_next = 1'b0;
			stop_next = 1'b0;
		end
		case (state_reg)
			NVCS_STORE: begin
				mem_next[idx_reg] = op_rdata;
				crc_next = crc_calc;
				idx_next = AW'(idx_reg + 1'b1);
				err_next = cmd_valid;
				if (last) begin
					sum_next = crc_calc;
					state_next = NVCS_IDLE;
					done_next = 1'b1;
				end
			end
			NVCS_RESTORE: begin
				crc_next = crc_calc;
				idx_next = AW'(idx_reg + 1'b1);
				err_next = cmd_valid;
				if (last) begin
					if (crc_calc != sum_reg) begin
						fault_next = 1'b1;
						if (ctrl_reg[`NVCS_BIT_CRC_STOP]) begin
							stop_next = 1'b1;
						end
					end
					state_next = NVCS_IDLE;
					done_next = 1'b1;
				end
			end
			NVCS_IDLE: begin
				if (cmd_valid && word_page) begin
					if (!ctrl_reg[`NVCS_BIT_WORD_EN]) begin
						err_next = 1'b1;
					end else if (cmd_write && (!cmd_has_data || !unlocked)) begin
						err_next = 1'b1;
					end else if (cmd_page == `NVCS_PAGE_WORD_LO) begin
						if (!in_range) begin
							err_next = 1'b1;
						end else if (cmd_write) begin
							mem_next[cmd_code[AW-1:0]] = cmd_wdata;
							done_next = 1'b1;
						end else begin
							rdata_next = mem_reg[cmd_code[AW-1:0]];
							done_next = 1'b1;
						end
					end else if (cmd_code == `NVCS_HI_SEL_SUM) begin
						if (cmd_write) begin
							sum_next = cmd_wdata;
						end
						rdata_next = cmd_write ? rdata_reg : sum_reg;
						done_next = 1'b1;
					end else if (cmd_code == `NVCS_HI_SEL_FAULT) begin
						if (cmd_write) begin
							frec_next = cmd_wdata;
						end
						rdata_next = cmd_write ? rdata_reg : frec_reg;
						done_next = 1'b1;
					end else begin
						err_next = 1'b1;
					end
				end else if (cmd_valid) begin
					case (cmd_code)
						`NVCS_OFF_CONTROL: begin
							if (cmd_write && cmd_has_data) begin
								ctrl_next = cmd_wdata & `NVCS_CTRL_MASK;
								done_next = 1'b1;
							end else if (!cmd_write) begin
								rdata_next = ctrl_reg;
								done_next = 1'b1;
							end else begin
								err_next = 1'b1;
							end
						end
						`NVCS_OFF_GUARD: begin
							if (cmd_write && cmd_has_data) begin
								guard_next = cmd_wdata;
								done_next = 1'b1;
							end else if (!cmd_write) begin
								rdata_next = guard_reg;
								done_next = 1'b1;
							end else begin
								err_next = 1'b1;
							end
						end
						`NVCS_CMD_STORE: begin
							if (!cmd_write || cmd_has_data) begin
								err_next = 1'b1;
							end else if (!unlocked) begin
								err_next = 1'b1;
							end else begin
								state_next = NVCS_STORE;
								idx_next = '0;
								crc_next = `NVCS_CRC_INIT;
							end
						end
						`NVCS_CMD_RESTORE: begin
							if (!cmd_write || cmd_has_data) begin
								err_next = 1'b1;
							end else if (power_on) begin
								err_next = 1'b1;
							end else begin
								state_next = NVCS_RESTORE;
								idx_next = '0;
								crc_next = `NVCS_CRC_INIT;
							end
						end
						default: begin
							err_next = 1'b1;
						end
					endcase
				end
			end
			default: begin
				state_next = NVCS_IDLE;
			end
		endcase
		if (fault_event && ctrl_reg[`NVCS_BIT_FAULT_SAVE]) begin
			frec_next = fault_code;
		end
	end

	// Reset starts in restore: the power-on copy runs by itself
	always_ff @(posedge clock or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state_reg <= NVCS_RESTORE;
			idx_reg <= '0;
			crc_reg <= `NVCS_CRC_INIT;
			ctrl_reg <= `NVCS_CTRL_RESET;
			guard_reg <= `NVCS_GUARD_RESET;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= `NVCS_MEM_RESET;
			end
			sum_reg <= `NVCS_SUM_RESET;
			frec_reg <= `NVCS_MEM_RESET;
			fault_reg <= 1'b0;
			stop_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			crc_reg <= crc_next;
			ctrl_reg <= ctrl_next;
			guard_reg <= guard_next;
			mem_reg <= mem_next;
			sum_reg <= sum_next;
			frec_reg <= frec_next;
			fault_reg <= fault_next;
			stop_reg <= stop_next;
			done_reg <= done_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
		end
	end

	assign cmd_done = done_reg;
	assign cmd_err = err_reg;
	assign cmd_rdata = rdata_reg;
	assign op_addr = idx_reg;
	assign op_we = (state_reg == NVCS_RESTORE);
	assign op_wdata = mem_reg[idx_reg];
	assign status_cml_crc = fault_reg;
	assign shutdown_req = stop_reg;
	assign busy = (state_reg != NVCS_IDLE);

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n_sync);

	sequence store_cmd_s;
		cmd_valid && !busy && !word_page && cmd_code == `NVCS_CMD_STORE &&
			cmd_write && !cmd_has_data;
	endsequence
	sequence restore_cmd_s;
		cmd_valid && !busy && !word_page && cmd_code == `NVCS_CMD_RESTORE &&
			cmd_write && !cmd_has_data;
	endsequence
	sequence restore_end_s;
		state_reg == NVCS_RESTORE && last;
	endsequence

	word_gate_a: assert property (cmd_valid && !busy && word_page &&
		!ctrl_reg[`NVCS_BIT_WORD_EN] |=> cmd_err && !cmd_done)
		else $error("word access done while disabled");
	fault_save_a: assert property (fault_event &&
		ctrl_reg[`NVCS_BIT_FAULT_SAVE] |=> frec_reg == $past(fault_code))
		else $error("fault status not recorded");
	crc_nostop_a: assert property (restore_end_s ##0
		(crc_calc != sum_reg && !ctrl_reg[`NVCS_BIT_CRC_STOP] &&
		!stop_reg) |=> status_cml_crc && !shutdown_req)
		else $error("mismatch stopped output with stop bit clear");
	crc_stop_a: assert property (restore_end_s ##0
		(crc_calc != sum_reg && ctrl_reg[`NVCS_BIT_CRC_STOP])
		|=> shutdown_req && status_cml_crc)
		else $error("mismatch did not request shutdown");
	sum_saved_a: assert property (state_reg == NVCS_STORE && last
		|=> sum_reg == $past(crc_calc) && !busy && cmd_done)
		else $error("checksum not stored at end of save");
	crc_check_a: assert property (restore_end_s ##0
		(crc_calc == sum_reg && !fault_reg && !crc_fault_clear)
		|=> !status_cml_crc)
		else $error("checksum fault on matching restore");
	guard_block_a: assert property (store_cmd_s ##0 !unlocked
		|=> !busy && cmd_err && $stable(sum_reg))
		else $error("save ran with guard locked");
	store_run_a: assert property (store_cmd_s ##0 unlocked
		|=> busy && op_addr == '0 && !op_we)
		else $error("save did not start");
	bare_cmd_a: assert property (cmd_valid && !busy && !word_page &&
		(cmd_code == `NVCS_CMD_STORE || cmd_code == `NVCS_CMD_RESTORE) &&
		(!cmd_write || cmd_has_data) |=> cmd_err && !busy)
		else $error("malformed save or restore accepted");
	restore_run_a: assert property (restore_cmd_s ##0 !power_on
		|=> op_we [*2])
		else $error("restore did not write operating memory");
	power_block_a: assert property (restore_cmd_s ##0 power_on
		|=> !busy && cmd_err)
		else $error("restore accepted while output on");
	por_restore_a: assert property ($rose(rst_n_sync) |->
		state_reg == NVCS_RESTORE && op_addr == '0)
		else $error("no restore after power-on reset");
endmodule
`default_nettype wire

// >>> bench/nvcs_host.sv
// Purpose: Host model that issues decoded commands to the store block.
// Assumes: Every answer arrives within 64 cycles of the request.
// Notes: A request is launched after a rising edge and stands one cycle.
`timescale 1ns/100ps
`default_nettype none
module nvcs_host (
	input wire logic clock, // Core clock
	output logic cmd_valid, // Command strobe
	output logic [7:0] cmd_code, // Code or word index
	output logic [7:0] cmd_page, // Bus page
	output logic cmd_write, // Write when high
	output logic cmd_has_data, // Data byte present
	output logic [7:0] cmd_wdata, // Data byte
	input wire logic cmd_done, // Completed pulse
	input wire logic cmd_err, // Refused pulse
	input wire logic [7:0] cmd_rdata // Read data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_page = 8'h00;
		cmd_write = 1'b0;
		cmd_has_data = 1'b0;
		cmd_wdata = 8'h00;
	end
	// Bare code for save and restore is up to the caller
	task automatic xfer(input logic [7:0] c, p, input logic w, h,
		input logic [7:0] d, output logic dn, er, output logic [7:0] rd);
		int n;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_page <= p;
		cmd_write <= w;
		cmd_has_data <= h;
		cmd_wdata <= d;
		@(posedge clock);
		cmd_valid <= 1'b0;
		// Code and data lines stop showing the last value
		cmd_code <= ~c;
		cmd_wdata <= ~d;
		dn = 1'b0;
		er = 1'b0;
		rd = 8'h00;
		for (n = 0; n < 64 && dn !== 1'b1 && er !== 1'b1; n++) begin
			@(negedge clock);
			dn = cmd_done;
			er = cmd_err;
			rd = cmd_rdata;
		end
	endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Purpose: Self-checking bench of the store and restore block.
// Assumes: Host model drives the command port; bench holds op memory.
// Notes: Nonvolatile contents are modelled in an array of the bench.
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int D = 8;
	logic clock, reset_n, power_on, fault_event, crc_fault_clear;
	logic cmd_valid, cmd_write, cmd_has_data, cmd_done, cmd_err, op_we;
	logic [7:0] cmd_code, cmd_page, cmd_wdata, cmd_rdata, fault_code;
	logic [7:0] op_rdata, op_wdata;
	logic status_cml_crc, shutdown_req, busy;
	logic [$clog2(D)-1:0] op_addr;
	logic [7:0] om [D];
	logic [7:0] nv [D];
	int failures = 0;
	int comparisons = 0;
	nvcs_host host (.clock(clock), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_page(cmd_page), .cmd_write(cmd_write),
		.cmd_has_data(cmd_has_data), .cmd_wdata(cmd_wdata),
		.cmd_done(cmd_done), .cmd_err(cmd_err), .cmd_rdata(cmd_rdata));
	nvcs_store_restore #(.DEPTH(D)) uut (.clock(clock), .reset_n(reset_n),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_page(cmd_page),
		.cmd_write(cmd_write), .cmd_has_data(cmd_has_data),
		.cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_err(cmd_err),
		.cmd_rdata(cmd_rdata), .op_addr(op_addr), .op_rdata(op_rdata),
		.op_we(op_we), .op_wdata(op_wdata), .power_on(power_on),
		.fault_event(fault_event), .fault_code(fault_code),
		.crc_fault_clear(crc_fault_clear), .status_cml_crc(status_cml_crc),
		.shutdown_req(shutdown_req), .busy(busy));
	assign op_rdata = om[op_addr];
	always @(posedge clock) if (op_we === 1'b1) om[op_addr] <= op_wdata;
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	function automatic logic [7:0] crc8();
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < D; i++) begin
			c ^= nv[i];
			for (int b = 0; b < 8; b++) begin
				c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
			end
		end
		return c;
	endfunction
	task automatic check(input string n, input logic [7:0] e, g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic op(input logic [7:0] c, p, input logic w, h,
		input logic [7:0] d, input logic ok, input logic [7:0] ex);
		logic dn, er;
		logic [7:0] r;
		host.xfer(c, p, w, h, d, dn, er, r);
		check("answer", {6'h00, ok, !ok}, {6'h00, dn, er});
		if (ok && !w) check("rdata", ex, r);
	endtask
	task automatic rs(input logic [1:0] st);
		op(8'h16, 8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 8'h00);
		check("status", {6'h00, st}, {6'h00, shutdown_req, status_cml_crc});
		for (int i = 0; i < D; i++) check("opmem", nv[i], om[i]);
	endtask
	task automatic pulse(input logic f);
		@(posedge clock);
		fault_event <= f;
		crc_fault_clear <= !f;
		@(posedge clock);
		fault_event <= 1'b0;
		crc_fault_clear <= 1'b0;
		@(negedge clock);
	endtask
	task end_of_test;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#80000;
		failures++;
		end_of_test;
	end
	initial begin
		reset_n = 1'b0;
		{power_on, fault_event, crc_fault_clear} = 3'b000;
		fault_code = 8'h00;
		for (int i = 0; i < D; i++) om[i] = 8'hA5;
		for (int i = 0; i < D; i++) nv[i] = 8'h00;
		void'($urandom(310));
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		for (int n = 0; n < 64 && busy !== 1'b0; n++) @(negedge clock);
		check("busy", 8'h00, {7'h00, busy});
		for (int i = 0; i < D; i++) check("opmem", 8'h00, om[i]);
		op(8'h06, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 8'h00);
		op(8'h13, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 8'h00);
		op(8'h06, 8'h00, 1'b1, 1'b1, 8'hFF, 1'b1, 8'h00);
		op(8'h06, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 8'h07);
		op(8'h06, 8'h00, 1'b1, 1'b1, 8'h04, 1'b1, 8'h00);
		for (int i = 0; i < D; i++) om[i] = 8'($urandom);
		op(8'h15, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 8'h00);
		op(8'h00, 8'h1D, 1'b0, 1'b0, 8'h00, 1'b1, 8'h00);
		op(8'h13, 8'h00, 1'b1, 1'b1, 8'h63, 1'b1, 8'h00);
		op(8'h15, 8'h00, 1'b1, 1'b1, 8'h00, 1'b0, 8'h00);
		op(8'h16, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00);
		op(8'h15, 8'h00, 1'b1, 1'b0, 8'h00, 1'b1, 8'h00);
		for (int i = 0; i < D; i++) nv[i] = om[i];
		for (int i = 0; i < D; i++) begin
			op(8'(i), 8'h1C, 1'b0, 1'b0, 8'h00, 1'b1, nv[i]);
		end
		op(8'h00, 8'h1D, 1'b0, 1'b0, 8'h00, 1'b1, crc8());
		op(8'(D), 8'h1C, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00);
		for (int i = 0; i < D; i++) om[i] = ~nv[i];
		@(posedge clock);
		power_on <= 1'b1;
		op(8'h16, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 8'h00);
		check("opmem", ~nv[0], om[0]);
		@(posedge clock);
		power_on <= 1'b0;
		rs(2'b00);
		op(8'h00, 8'h1C, 1'b1, 1'b1, ~nv[0], 1'b1, 8'h00);
		nv[0] = ~nv[0];
		rs(2'b01);
		pulse(1'b0);
		check("status", 8'h00, {7'h00, status_cml_crc});
		op(8'h06, 8'h00, 1'b1, 1'b1, 8'h05, 1'b1, 8'h00);
		rs(2'b11);
		pulse(1'b0);
		op(8'h06, 8'h00, 1'b1, 1'b1, 8'h06, 1'b1, 8'h00);
		@(posedge clock);
		fault_code <= 8'($urandom);
		pulse(1'b1);
		op(8'h01, 8'h1D, 1'b0, 1'b0, 8'h00, 1'b1, fault_code);
		op(8'h06, 8'h00, 1'b1, 1'b1, 8'h04, 1'b1, 8'h00);
		@(posedge clock);
		fault_code <= ~fault_code;
		pulse(1'b1);
		op(8'h01, 8'h1D, 1'b0, 1'b0, 8'h00, 1'b1, ~fault_code);
		op(8'h02, 8'h1D, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00);
		op(8'h06, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 8'h00);
		op(8'h00, 8'h1D, 1'b1, 1'b1, ~crc8(), 1'b1, 8'h00);
		op(8'h00, 8'h1D, 1'b0, 1'b0, 8'h00, 1'b1, ~crc8());
		rs(2'b01);
		op(8'h00, 8'h1D, 1'b1, 1'b1, crc8(), 1'b1, 8'h00);
		pulse(1'b0);
		rs(2'b00);
		op(8'h13, 8'h00, 1'b1, 1'b1, 8'h00, 1'b1, 8'h00);
		op(8'h01, 8'h1C, 1'b1, 1'b1, ~nv[1], 1'b0, 8'h00);
		op(8'h01, 8'h1C, 1'b0, 1'b0, 8'h00, 1'b1, nv[1]);
		op(8'h06, 8'h00, 1'b1, 1'b1, 8'h00, 1'b1, 8'h00);
		op(8'h00, 8'h1C, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00);
		end_of_test;
	end
endmodule
`default_nettype wire
